/* File: psmc_map.vh */
// Constants of the sleep-mode control block: opcode patterns, operand
// fields, pipeline depth and state codes.
// Assumes a four-stage pipeline whose stages report valid bits to this block.
// How it works
// - Wait instruction sleeps until interrupt or restart
// - Sleep freezes pipeline, disables RAMs, gates clocks
// - Decode 32-bit word, six-bit immediate or register
// - Condition flags untouched; only dozing flag set
// - Stall fetch, drain pipeline, then set flag
// - Host access and halt keep working in sleep
// - Host cannot clear flag; halt-restart wakes
// - Program counter holds next sequential address
// - Enables from status write act at stage three
// - Later variant uses low two operand bits
// - Operand 1,2,3 sets level enables as tabled
// - Interrupt wake clears flag, kills stage one
// - Restart after halt clears dozing flag
// - Single-step makes wait behave as no-op
// - Slow fetch may split status write and wait
`ifndef PSMC_MAP_VH
`define PSMC_MAP_VH

// Opcode match: bits other than the operand field
`define PSMC_OP_MASK      32'hFFFFF03F
`define PSMC_OP_IMM       32'h216F003F
`define PSMC_OP_REG       32'h212F003F
`define PSMC_SRC_HI       11
`define PSMC_SRC_LO       6
`define PSMC_SRC_W        6
`define PSMC_REG_NUM_W    6
// Pipeline depth and the stage whose flag write takes effect
`define PSMC_STAGES       4
`define PSMC_WB_STAGE     3
// Operand encodings
`define PSMC_EN_KEEP      2'h0
`define PSMC_EN_L1        0
`define PSMC_EN_L2        1
// Reset value of the captured program counter
`define PSMC_PC_RST       32'h00000000
// Synchronised pin inputs
`define PSMC_PIN_IRQ      0
`define PSMC_PIN_HALT     1
`define PSMC_PIN_STEP     2
`define PSMC_PIN_N        3
// Controller states
`define PSMC_ST_RUN       2'h0
`define PSMC_ST_DRAIN     2'h1
`define PSMC_ST_SLEEP     2'h2
`define PSMC_ST_W         2

`endif

/* File: psmc_sync.v */
// Three-stage synchroniser with agreement filter for one level input.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
module psmc_sync
(
    // Clock and reset
    input  wire sys_clk,
    input  wire reset_n,
    // Level in and filtered level out
    input  wire async_in,
    output reg  sync_out
);
    reg meta_reg;
    reg s2_reg;
    reg s3_reg;

    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            meta_reg <= 1'b0;
            s2_reg   <= 1'b0;
            s3_reg   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_reg <= async_in;
            s2_reg   <= meta_reg;
            s3_reg   <= s2_reg;
            // Change counts once second and third stages agree
            if (s2_reg == s3_reg)
                sync_out <= s3_reg;
        end
    end
endmodule

/* File: psmc_decode.v */
// Decoder of the low-power wait instruction and its operand.
// Assumes the register operand value is supplied by the register file.
`timescale 1ns/1ps
`include "psmc_map.vh"
module psmc_decode
(
    // Instruction at decode
    input  wire        dec_valid,
    input  wire [31:0] dec_instr,
    input  wire [31:0] dec_reg_value,
    // Decoded result
    output wire        is_wait,
    output wire [1:0]  enable_bits,
    output wire [`PSMC_REG_NUM_W-1:0] src_reg_num
);
    function match_op;
        input [31:0] word;
        input [31:0] pattern;
        begin
            match_op = ((word & `PSMC_OP_MASK) == pattern);
        end
    endfunction

    wire imm_form;
    wire reg_form;
    wire [`PSMC_SRC_W-1:0] field;
    wire [`PSMC_SRC_W-1:0] operand;

    assign imm_form    = match_op(dec_instr, `PSMC_OP_IMM);
    assign reg_form    = match_op(dec_instr, `PSMC_OP_REG);
    assign is_wait     = dec_valid & (imm_form | reg_form);
    assign field       = dec_instr[`PSMC_SRC_HI:`PSMC_SRC_LO];
    assign src_reg_num = field;
    // Register form takes the value, immediate form the field itself
    assign operand     = reg_form ? dec_reg_value[`PSMC_SRC_W-1:0] : field;
    // Upper four operand bits ignored
    assign enable_bits = operand[`PSMC_EN_L2:`PSMC_EN_L1];
endmodule

/* File: psmc_ctrl.v */
// Sleep-mode controller of the processor core: drains the pipeline on the
// low-power wait instruction, holds the dozing state and handles wake-up.
// Assumes stage valid bits, host halt/run levels and an interrupt request
// level; the condition flags live outside and are never touched here.
`timescale 1ns/1ps
`include "psmc_map.vh"
module psmc_ctrl
#(
    // 1 selects the later variant with operand-driven enables
    parameter LATER_VARIANT = 1,
    // 1 gates non-essential clocks while sleeping
    parameter CLOCK_GATING  = 1
)
(
    // Clock and reset
    input  wire        sys_clk,
    input  wire        reset_n,
    // Instruction at decode
    input  wire        dec_valid,
    input  wire [31:0] dec_instr,
    input  wire [31:0] dec_reg_value,
    input  wire [31:0] dec_next_pc,
    output wire [5:0]  src_reg_num,
    // Pipeline occupancy of the stages after decode
    input  wire [`PSMC_STAGES-1:1] stage_valid,
    // Status-bits write retiring at the write-back stage
    input  wire        flag_write,
    input  wire [1:0]  flag_write_en,
    // Interrupt request and host debug pins
    input  wire        irq_request,
    input  wire        host_halt,
    input  wire        single_step,
    // Pipeline control
    output wire        fetch_stall,
    output wire        pipe_freeze,
    output wire        kill_stage1,
    output wire        wait_as_nop,
    output reg         irq_take,
    // Power control
    output reg         ram_disable,
    output reg         clk_gate_off,
    // State visible to software and host
    output reg         dozing_flag,
    output reg         level1_irq_enable,
    output reg         level2_irq_enable,
    output reg  [31:0] sleep_pc,
    output reg         halted
);
    reg [`PSMC_ST_W-1:0]   state_reg;
    reg [`PSMC_ST_W-1:0]   state_next;
    reg [1:0]              pend_en_reg;
    reg [1:0]              pend_en_next;
    reg                    restart_pend_reg;
    reg                    restart_pend_next;
    reg [31:0]             sleep_pc_next;
    reg [1:0]              level_en_next;

    wire [`PSMC_PIN_N-1:0] pin_raw;
    wire [`PSMC_PIN_N-1:0] pin_sync;
    wire                   irq_sync;
    wire                   halt_sync;
    wire                   step_sync;
    wire                   is_wait;
    wire [1:0]             enable_bits;
    wire                   pipe_empty;
    wire                   irq_allowed;
    wire                   wake_irq;
    wire                   in_run;
    wire                   in_drain;
    wire                   in_sleep;
    wire                   wait_taken;
    wire                   drain_done;
    wire                   sleep_next;
    genvar                 pin_idx;

    // State match, used by every state flag below
    function state_is;
        input [`PSMC_ST_W-1:0] current;
        input [`PSMC_ST_W-1:0] wanted;
        begin
            state_is = (current == wanted);
        end
    endfunction

    // Pin inputs from the host and interrupt sources
    assign pin_raw[`PSMC_PIN_IRQ]  = irq_request;
    assign pin_raw[`PSMC_PIN_HALT] = host_halt;
    assign pin_raw[`PSMC_PIN_STEP] = single_step;

    generate
        for (pin_idx = 0; pin_idx < `PSMC_PIN_N; pin_idx = pin_idx + 1)
        begin : pin_sync_gen
            psmc_sync u_sync
            (
                .sys_clk  (sys_clk),
                .reset_n  (reset_n),
                .async_in (pin_raw[pin_idx]),
                .sync_out (pin_sync[pin_idx])
            );
        end
    endgenerate

    assign irq_sync  = pin_sync[`PSMC_PIN_IRQ];
    assign halt_sync = pin_sync[`PSMC_PIN_HALT];
    assign step_sync = pin_sync[`PSMC_PIN_STEP];

    psmc_decode u_decode
    (
        .dec_valid     (dec_valid),
        .dec_instr     (dec_instr),
        .dec_reg_value (dec_reg_value),
        .is_wait       (is_wait),
        .enable_bits   (enable_bits),
        .src_reg_num   (src_reg_num)
    );

    assign in_run     = state_is(state_reg, `PSMC_ST_RUN);
    assign in_drain   = state_is(state_reg, `PSMC_ST_DRAIN);
    assign in_sleep   = state_is(state_reg, `PSMC_ST_SLEEP);
    assign pipe_empty = ~(|stage_valid);
    assign wait_taken = in_run & is_wait & ~step_sync & ~halted;
    assign drain_done = in_drain & pipe_empty;
    assign sleep_next = state_is(state_next, `PSMC_ST_SLEEP);

    // Enables count once written back, so no interrupt slips in early;
    // a wait fetched late behind the write can still be preceded by one
    assign irq_allowed = level1_irq_enable | level2_irq_enable;
    assign wake_irq    = irq_sync & irq_allowed & ~halted;

    // Single-step: instruction passes as a no-op
    assign wait_as_nop = is_wait & step_sync;
    // Fetch stalls from decode of the wait until wake-up
    assign fetch_stall = in_drain | in_sleep
                         | (is_wait & ~step_sync & in_run);
    // Stalled but not halted; host path stays live
    assign pipe_freeze = in_sleep;
    assign kill_stage1 = in_sleep & wake_irq;

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            `PSMC_ST_RUN:
            begin
                if (wait_taken)
                    state_next = `PSMC_ST_DRAIN;
            end
            `PSMC_ST_DRAIN:
            begin
                // Older instructions complete before the flag rises
                if (pipe_empty)
                    state_next = `PSMC_ST_SLEEP;
            end
            `PSMC_ST_SLEEP:
            begin
                // Each single step is a restart, so step mode never stays asleep
                if (wake_irq | restart_pend_reg | step_sync)
                    state_next = `PSMC_ST_RUN;
            end
            default:
                state_next = `PSMC_ST_RUN;
        endcase
    end

    // Next values of the restart, capture and enable registers
    always @*
    begin
        restart_pend_next = restart_pend_reg;
        pend_en_next      = pend_en_reg;
        sleep_pc_next     = sleep_pc;
        level_en_next     = {level2_irq_enable, level1_irq_enable};
        // Halt then run while sleeping is a restart; flag not cleared directly
        if (!in_sleep)
            restart_pend_next = 1'b0;
        else if (halted & ~halt_sync)
            restart_pend_next = 1'b1;
        if (wait_taken)
        begin
            sleep_pc_next = dec_next_pc;
            pend_en_next  = enable_bits;
        end
        // Status-bits write updates enables at write-back only, and wins
        if (flag_write)
            level_en_next = flag_write_en;
        else if ((LATER_VARIANT != 0) && drain_done
                 && pend_en_reg != `PSMC_EN_KEEP)
            level_en_next = pend_en_reg;
    end

    // Controller state
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_reg <= `PSMC_ST_RUN;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Host halt level, one stage after the synchroniser
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            halted <= 1'b0;
        end
        else
        begin
            halted <= halt_sync;
        end
    end

    // Restart seen while sleeping
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            restart_pend_reg <= 1'b0;
        end
        else
        begin
            restart_pend_reg <= restart_pend_next;
        end
    end

    // Address after the wait, held through the sleep
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            sleep_pc <= `PSMC_PC_RST;
        end
        else
        begin
            sleep_pc <= sleep_pc_next;
        end
    end

    // Operand enables, applied once the drain ends
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            pend_en_reg <= `PSMC_EN_KEEP;
        end
        else
        begin
            pend_en_reg <= pend_en_next;
        end
    end

    // Dozing flag is the only flag this instruction touches
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            dozing_flag <= 1'b0;
        end
        else
        begin
            dozing_flag <= sleep_next;
        end
    end

    // Memories off while sleeping
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            ram_disable <= 1'b0;
        end
        else
        begin
            ram_disable <= sleep_next;
        end
    end

    // Clock gate only where the option is built in
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            clk_gate_off <= 1'b0;
        end
        else
        begin
            clk_gate_off <= (CLOCK_GATING != 0) && sleep_next;
        end
    end

    // Interrupt-level enables
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            level1_irq_enable <= 1'b0;
            level2_irq_enable <= 1'b0;
        end
        else
        begin
            level1_irq_enable <= level_en_next[`PSMC_EN_L1];
            level2_irq_enable <= level_en_next[`PSMC_EN_L2];
        end
    end

    // Interrupt taken one cycle after the kill
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            irq_take <= 1'b0;
        end
        else
        begin
            irq_take <= kill_stage1;
        end
    end
endmodule

/* File: psmc_monitor.sv */
// Port checker of the sleep-mode controller.
// Assumes a bind onto psmc_ctrl, one clock.
`timescale 1ns/1ps
module psmc_monitor
(
    // Clock and reset
    input wire        sys_clk,
    input wire        reset_n,
    // Watched ports
    input wire [3:1]  stage_valid,
    input wire        fetch_stall,
    input wire        pipe_freeze,
    input wire        kill_stage1,
    input wire        irq_take,
    input wire        ram_disable,
    input wire        dozing_flag,
    input wire [31:0] sleep_pc
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    doze_freeze_a: assert property (dozing_flag == pipe_freeze)
        else $error("freeze mismatch");
    doze_ram_a: assert property (dozing_flag |-> ram_disable)
        else $error("ram on in sleep");
    doze_stall_a: assert property (dozing_flag |-> fetch_stall)
        else $error("fetch in sleep");
    drain_first_a: assert property ($rose(dozing_flag) |-> $past(stage_valid) == 3'h0)
        else $error("sleep before drain");
    kill_take_a: assert property (kill_stage1 |=> irq_take)
        else $error("no irq after kill");
    wake_clear_a: assert property (kill_stage1 |=> !dozing_flag)
        else $error("flag kept on wake");
    take_cause_a: assert property (irq_take && $past(dozing_flag) |-> $past(kill_stage1))
        else $error("irq without kill");
    pc_hold_a: assert property (dozing_flag && $past(dozing_flag) |-> $stable(sleep_pc))
        else $error("pc moved in sleep");
    cover property (kill_stage1);
    cover property ($rose(dozing_flag));
    cover property ($fell(dozing_flag) && !irq_take);
endmodule
bind psmc_ctrl psmc_monitor psmc_monitor_i (.sys_clk(sys_clk), .reset_n(reset_n), .stage_valid(stage_valid),
    .fetch_stall(fetch_stall), .pipe_freeze(pipe_freeze), .kill_stage1(kill_stage1), .irq_take(irq_take),
    .ram_disable(ram_disable), .dozing_flag(dozing_flag), .sleep_pc(sleep_pc));

/* File: psmc_host_model.sv */
// Host debug pins and interrupt source of the sleep-mode controller.
// Assumes one-cycle commands from the bench on sys_clk.
`timescale 1ns/1ps
module psmc_host_model
(
    // Clock and reset
    input  wire sys_clk,
    input  wire reset_n,
    // Bench commands and core answer
    input  wire irq_cmd,
    input  wire restart_cmd,
    input  wire step_cmd,
    input  wire irq_take,
    // Pins into the core
    output reg  irq_request = 1'b0,
    output reg  host_halt = 1'b0,
    output reg  single_step = 1'b0
);
    reg [4:0] halt_cnt_reg = 5'h0;
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            irq_request <= 1'b0;
            host_halt <= 1'b0;
            single_step <= 1'b0;
            halt_cnt_reg <= 5'h0;
        end
        else
        begin
            // Level request held until the core takes it
            irq_request <= (irq_request | irq_cmd) & ~irq_take;
            single_step <= step_cmd;
            // Halt for a while, then release as the restart
            // Pin halt only, never a status-bits halt ahead of a wait
            halt_cnt_reg <= restart_cmd ? 5'h10 : halt_cnt_reg - (halt_cnt_reg != 5'h0);
            host_halt <= restart_cmd | (halt_cnt_reg > 5'h1);
        end
    end
endmodule

/* File: testbench.sv */
// Bench of the sleep-mode controller.
// Assumes psmc_ctrl, the host model and the bound checker.
`timescale 1ns/1ps
`include "psmc_map.vh"
module testbench;
    reg         sys_clk = 1'b0, reset_n = 1'b0, dec_valid = 1'b0, flag_write = 1'b0;
    reg         irq_cmd = 1'b0, restart_cmd = 1'b0, step_cmd = 1'b0;
    reg  [31:0] dec_instr = 32'h0, dec_reg_value = 32'h0, dec_next_pc = 32'h0;
    reg  [3:1]  stage_valid = 3'h0;
    reg  [1:0]  flag_write_en = 2'h0;
    wire [5:0]  src_reg_num;
    wire [31:0] sleep_pc;
    wire        irq_request, host_halt, single_step, fetch_stall, pipe_freeze, kill_stage1, wait_as_nop;
    wire        irq_take, ram_disable, clk_gate_off, dozing_flag, level1_irq_enable, level2_irq_enable, halted;
    integer     mismatches = 0;
    integer     check_count = 0;
    always #2 sys_clk = ~sys_clk;
    psmc_ctrl psmc_ctrl_i (.sys_clk(sys_clk), .reset_n(reset_n), .dec_valid(dec_valid), .dec_instr(dec_instr),
        .dec_reg_value(dec_reg_value), .dec_next_pc(dec_next_pc), .src_reg_num(src_reg_num),
        .stage_valid(stage_valid), .flag_write(flag_write), .flag_write_en(flag_write_en),
        .irq_request(irq_request), .host_halt(host_halt), .single_step(single_step), .fetch_stall(fetch_stall),
        .pipe_freeze(pipe_freeze), .kill_stage1(kill_stage1), .wait_as_nop(wait_as_nop), .irq_take(irq_take),
        .ram_disable(ram_disable), .clk_gate_off(clk_gate_off), .dozing_flag(dozing_flag),
        .level1_irq_enable(level1_irq_enable), .level2_irq_enable(level2_irq_enable),
        .sleep_pc(sleep_pc), .halted(halted));
    psmc_host_model psmc_host_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .irq_cmd(irq_cmd),
        .restart_cmd(restart_cmd), .step_cmd(step_cmd), .irq_take(irq_take), .irq_request(irq_request),
        .host_halt(host_halt), .single_step(single_step));
    task check(input [31:0] seen, input [31:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("mismatch %0t seen %h exp %h", $time, seen, exp);
        end
    end
    endtask
    task complete_run;
    begin
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    task tick(input integer n);
    begin
        repeat (n) @(posedge sys_clk);
    end
    endtask
    task wait_doze(input exp);
        integer n;
    begin
        for (n = 0; dozing_flag !== exp; n = n + 1)
        begin
            if (n == 40)
            begin
                mismatches = mismatches + 1;
                complete_run;
            end
            @(posedge sys_clk);
            #1;
        end
    end
    endtask
    task issue(input [31:0] instr, input [31:0] pc, input stall, input nop); // Never after a branch
    begin
        @(posedge sys_clk);
        dec_valid <= 1'b1;
        dec_instr <= instr;
        dec_next_pc <= pc;
        stage_valid <= 3'h7;
        #1;
        check(wait_as_nop, nop);
        if (!nop)
            check(fetch_stall, stall);
        tick(1);
        dec_valid <= 1'b0;
        tick(2);
        stage_valid <= 3'h0;
        #1;
        check(dozing_flag, 1'b0);
    end
    endtask
    task sleep_irq(input [5:0] op, input [1:0] en);
    begin
        issue(`PSMC_OP_IMM | {20'h0, op, 6'h0}, 32'h100 + op, 1'b1, 1'b0);
        wait_doze(1'b1);
        check({level2_irq_enable, level1_irq_enable}, en);
        check(sleep_pc, 32'h100 + op);
        check(ram_disable & clk_gate_off, 1'b1);
        tick(8);
        irq_cmd <= 1'b1;
        #1;
        check(dozing_flag, 1'b1);
        tick(1);
        irq_cmd <= 1'b0;
        wait_doze(1'b0);
        tick(6);
    end
    endtask
    task sleep_restart;
    begin
        dec_reg_value <= 32'hFFFFFFF2;
        issue(`PSMC_OP_REG | 32'hA40, 32'h200, 1'b1, 1'b0);
        check(src_reg_num, 6'h29);
        wait_doze(1'b1);
        check({level2_irq_enable, level1_irq_enable}, 2'h2);
        tick(1);
        restart_cmd <= 1'b1;
        tick(1);
        restart_cmd <= 1'b0;
        tick(10);
        #1;
        check({halted, dozing_flag}, 2'h3);
        wait_doze(1'b0);
        tick(6);
    end
    endtask
    task step_nop;
    begin
        issue(32'h216F003E, 32'h300, 1'b0, 1'b0);
        tick(4);
        step_cmd <= 1'b1;
        tick(6);
        issue(`PSMC_OP_IMM, 32'h304, 1'b0, 1'b1);
        tick(6);
        #1;
        check(dozing_flag, 1'b0);
    end
    endtask
    initial
    begin
        tick(16);
        reset_n <= 1'b1;
        tick(4);
        #1;
        check(dozing_flag, 1'b0);
        tick(1);
        flag_write <= 1'b1;
        flag_write_en <= 2'h3;
        tick(1);
        flag_write <= 1'b0;
        sleep_irq(6'h3C, 2'h3);
        sleep_irq(6'h01, 2'h1);
        sleep_irq(6'h3E, 2'h2);
        sleep_irq(6'h03, 2'h3);
        sleep_restart;
        step_nop;
        complete_run;
    end
endmodule
